// file: logic/cache_maintenance_op_unit.sv
`timescale 1ns/1ns
// What this block does
// RL1: Two-bit selector picks I-cache, D-cache, reserved L3, or L2.
// RL2: Three-bit command field names the action on the selected line.
// RL3: Hit-type ops act on the enclosing line only on a hit.
// RL4: Address-type ops fetch the line from memory when absent.
// RL5: Index ops split address into byte offset, set index, way bits.
// RL6: Each L1 has four ways at one set index, chosen by way bits.
// RL7: Software should use unmapped cached addresses for index ops.
// RL8: Index invalidate clears the line, writing back dirty D/L2 lines first.
// RL9: Index load tag copies tag and doubleword into staging registers; for the D-cache only the low data word is copied.
// RL10: Index store tag writes tag from staging; zero gives empty line.
// RL11: Index store data writes staging data into the indexed line.
// RL12: Hit invalidate clears a hitting line without writeback.
// RL13: On D/L2, command 5 writes back a dirty hit then invalidates.
// RL14: On I-cache, command 5 fills the line a miss would choose.
// RL15: Hit writeback writes a dirty hit back and leaves it valid.
// RL16: Fetch and lock fills the normal victim, then locks it.
// RL17: Locking the last unlocked way at an index silently does nothing.
// RL18: Data-side ops compare set index against pending buffer entries.
// RL19: On a potential match the memory pipeline stalls until clear.
// RL20: Ops run after graduation; missing L1 hit ops sustain one per clock.
// RL21: A younger instruction hit by an incomplete op is replayed.
// RL22: L2 ops pace to the L2 clock ratio and complete slower.
// RL23: Tag staging carries valid and lock bits, each 1 when set.
// RL24: Ops naming the reserved L3 cache complete with no state change.
module cache_maintenance_op_unit
  import cache_op_pkg::*;
(
  input  wire logic                      clk_sys,      // Core clock
  input  wire logic                      resetn,       // Async reset, low
  input  wire logic                      op_valid,     // Graduated cache op
  input  wire cache_op_s                 op,           // Op code and address
  output logic                           op_ready,     // Unit can take an op
  output logic                           op_done,      // Op completed pulse
  output logic                           mem_stall,    // Memory pipe stall
  output logic                           replay,       // Replay younger pulse
  input  wire logic                      younger_valid,// Younger op waiting
  input  wire logic [31:0]               younger_addr, // Its address
  input  wire logic [FSB_N-1:0]          fsb_valid,    // Pending buffer entries
  input  wire logic [FSB_N*SET_BITS-1:0] fsb_index,    // Their set indexes
  input  wire logic                      dirty_valid,  // Store hit marks dirty
  input  wire logic [31:0]               dirty_addr,   // Store address
  input  wire logic [1:0]                l2_ratio,     // L2 divide minus one
  input  wire logic                      cop_we,       // Staging write
  input  wire logic [7:0]                cop_regsel,   // Staging select
  input  wire logic [31:0]               cop_wdata,    // Staging write data
  output logic [31:0]                    cop_rdata,    // Staging read data
  output logic                           mem_valid,    // Memory request
  output mem_req_s                       mem,          // Request contents
  input  wire logic                      mem_ack,      // Request finished
  input  wire logic [63:0]               mem_rdata     // Fill data
);

  logic             rst_meta, rst_n;
  state_e           state, next_state;
  post_e            post, next_post;
  cache_op_s        cur, eop;
  logic [1:0]       cur_way, rr;
  logic             cur_lock;
  logic [1:0]       div_cnt;
  logic [3:0]       l2_cnt;
  logic             l2_tick;
  logic [TAG_W-1:0] tag_mem  [NCACHE][SETS][WAYS];
  logic [63:0]      data_mem [NCACHE][SETS][WAYS];
  logic [WAYS-1:0]  vld [NCACHE][SETS];
  logic [WAYS-1:0]  lck [NCACHE][SETS];
  logic [WAYS-1:0]  drt [NCACHE][SETS];
  logic [31:0]      itag_lo, itag_hi, idata_lo, idata_hi;
  logic [31:0]      dtag_lo, dtag_hi, ddata_lo;
  logic [31:0]      l2tag_lo, l2data_lo, l2data_hi;
  logic [1:0]       c, hway, vic, tway, iway, next_way;
  logic [SET_BITS-1:0] set;
  logic [TAG_W-1:0] tagv;
  logic [WAYS-1:0]  vl, lk, dk;
  logic             hit, vic_ok, fsb_hit, accept, exec_go, wait_done;
  logic             act_inv, act_clean, act_ldtag, act_sttag, act_stdata;
  logic             act_lock, act_fill, start_wb, start_fill, finish, lock_ok;
  logic [31:0]      stg_tag;
  logic [63:0]      stg_data;

  // Map selector to array slot
  function automatic logic [1:0] arr_of(input logic [1:0] s);
    arr_of = (s == SEL_L2) ? 2'h2 : {1'b0, s[0]};
  endfunction : arr_of

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Operand view and line lookup
  always_comb begin
    eop  = (state == ST_IDLE) ? op : cur;
    c    = arr_of(eop.sel);                                          // RL1
    set  = eop.addr[SET_LSB +: SET_BITS];                            // RL5
    iway = eop.addr[WAY_LSB +: WAY_BITS];                            // RL5 RL6
    tagv = eop.addr[31:TAG_LSB];
    vl   = vld[c][set];
    lk   = lck[c][set];
    dk   = drt[c][set];
    hit  = 1'b0;
    hway = 2'h0;
    for (int i = 0; i < WAYS; i++) begin
      if (vl[i] && tag_mem[c][set][i] == tagv) begin                 // RL3
        hit  = 1'b1;
        hway = 2'(i);
      end
    end
  end

  // Victim choice as a miss would make it: invalid first, then unlocked
  always_comb begin
    logic [1:0] w;
    w      = 2'h0;
    vic    = 2'h0;
    vic_ok = 1'b0;
    for (int i = 0; i < WAYS; i++) begin
      w = rr + 2'(i);
      if (!vic_ok && !vl[w] && !lk[w]) begin
        vic    = w;
        vic_ok = 1'b1;
      end
    end
    for (int i = 0; i < WAYS; i++) begin
      w = rr + 2'(i);
      if (!vic_ok && !lk[w]) begin                                   // RL16
        vic    = w;
        vic_ok = 1'b1;
      end
    end
  end

  // Potential match against the fill/store buffer queue by set index
  always_comb begin
    fsb_hit = 1'b0;
    for (int i = 0; i < FSB_N; i++) begin
      if (fsb_valid[i] && fsb_index[i*SET_BITS +: SET_BITS] == set
          && eop.sel != SEL_ICACHE && eop.sel != SEL_L3) begin       // RL18
        fsb_hit = 1'b1;
      end
    end
  end

  assign accept    = op_valid && op_ready;
  assign wait_done = !fsb_hit && (cur.sel != SEL_L2 || l2_cnt == L2_OP_TICKS); // RL19 RL22
  assign exec_go   = (accept && !fsb_hit && op.sel != SEL_L2)        // RL20
                     || (state == ST_WAIT && wait_done);

  // Command decode and sequencing
  always_comb begin
    next_state = state;
    next_post  = post;
    next_way   = cur_way;
    tway       = iway;
    lock_ok    = 1'b0;
    act_inv    = 1'b0;
    act_clean  = 1'b0;
    act_ldtag  = 1'b0;
    act_sttag  = 1'b0;
    act_stdata = 1'b0;
    act_lock   = 1'b0;
    act_fill   = 1'b0;
    start_wb   = 1'b0;
    start_fill = 1'b0;
    finish     = 1'b0;
    if (accept && !exec_go) begin
      next_state = ST_WAIT;                                          // RL19 RL22
    end
    if (exec_go && eop.sel != SEL_L3) begin                          // RL24
      unique case (eop.cmd)                                          // RL2
        CMD_IDX_INV: begin
          if (eop.sel != SEL_ICACHE && vl[iway] && dk[iway]) begin   // RL8
            start_wb  = 1'b1;
            next_post = POST_INV;
          end else begin
            act_inv = 1'b1;                                          // RL8
          end
        end
        CMD_LD_TAG:  act_ldtag  = 1'b1;                              // RL9
        CMD_ST_TAG:  act_sttag  = 1'b1;                              // RL10
        CMD_ST_DATA: act_stdata = 1'b1;                              // RL11
        CMD_HIT_INV: begin
          tway    = hway;
          act_inv = hit;                                             // RL12
        end
        CMD_WBINV_FILL: begin
          if (eop.sel == SEL_ICACHE) begin
            tway       = vic;
            start_fill = !hit && vic_ok;                             // RL14
          end else if (hit) begin
            tway      = hway;
            start_wb  = dk[hway];                                    // RL13
            act_inv   = !dk[hway];
            next_post = POST_INV;
          end
        end
        CMD_HIT_WB: begin
          tway      = hway;
          start_wb  = hit && dk[hway];                               // RL15
          next_post = POST_CLEAN;
        end
        CMD_FETCH_LOCK: begin
          tway    = hit ? hway : vic;
          lock_ok = |(~lk & ~(4'h1 << tway));                        // RL17
          if (hit) begin
            act_lock = lock_ok;                                      // RL17
          end else if (vic_ok) begin
            start_wb   = vl[vic] && dk[vic];                         // RL16
            start_fill = !(vl[vic] && dk[vic]);                      // RL4
            next_post  = POST_FILL;
          end
        end
      endcase
    end
    if (exec_go) begin
      next_way   = tway;
      next_state = start_wb ? ST_WB : (start_fill ? ST_FILL : ST_IDLE);
      finish     = !start_wb && !start_fill;
    end
    if (state == ST_WB && mem_ack) begin
      tway       = cur_way;
      act_inv    = post == POST_INV;                                 // RL8 RL13
      act_clean  = post == POST_CLEAN;                               // RL15
      start_fill = post == POST_FILL;                                // RL16
      next_state = start_fill ? ST_FILL : ST_IDLE;
      finish     = !start_fill;
    end
    if (state == ST_FILL && mem_ack) begin
      tway       = cur_way;
      act_fill   = 1'b1;                                             // RL4 RL14
      next_state = ST_IDLE;
      finish     = 1'b1;
    end
  end

  // Staging views for the selected cache
  always_comb begin
    unique case (c)
      2'h0:    stg_tag = itag_lo;
      2'h1:    stg_tag = dtag_lo;
      default: stg_tag = l2tag_lo;
    endcase
    unique case (c)
      2'h0:    stg_data = {idata_hi, idata_lo};
      2'h1:    stg_data = {data_mem[c][set][tway][63:32], ddata_lo};
      default: stg_data = {l2data_hi, l2data_lo};
    endcase
  end

  // Sequencer state and latched operand
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      post     <= POST_INV;
      cur      <= '0;
      cur_way  <= 2'h0;
      cur_lock <= 1'b0;
      op_ready <= 1'b0;
      op_done  <= 1'b0;
      mem_stall <= 1'b0;
    end else begin
      state     <= next_state;
      post      <= next_post;
      cur_way   <= next_way;
      op_ready  <= next_state == ST_IDLE;                            // RL20
      mem_stall <= next_state != ST_IDLE;                            // RL19
      op_done   <= finish;
      if (accept) begin
        cur <= op;
      end
      if (exec_go) begin
        cur_lock <= eop.cmd == CMD_FETCH_LOCK && eop.sel != SEL_ICACHE ? lock_ok
                    : eop.cmd == CMD_FETCH_LOCK && lock_ok;          // RL16
      end
    end
  end

  // L2 clock-ratio divider and op pacing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
      l2_tick <= 1'b0;
      l2_cnt  <= 4'h0;
    end else begin
      div_cnt <= (div_cnt == l2_ratio) ? 2'h0 : div_cnt + 2'h1;
      l2_tick <= div_cnt == l2_ratio;
      if (accept) begin
        l2_cnt <= 4'h0;
      end else if (l2_tick && l2_cnt != L2_OP_TICKS) begin
        l2_cnt <= l2_cnt + 4'h1;                                     // RL22
      end
    end
  end

  // Memory requests for writeback and fill
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem       <= '0;
      rr        <= 2'h0;
    end else begin
      if (mem_ack) begin
        mem_valid <= 1'b0;
      end
      if (start_wb) begin
        mem_valid <= 1'b1;
        mem.write <= 1'b1;
        mem.addr  <= {tag_mem[c][set][tway], set, 5'h00};
        mem.wdata <= data_mem[c][set][tway];
      end else if (start_fill) begin
        mem_valid <= 1'b1;                                           // RL4
        mem.write <= 1'b0;
        mem.addr  <= {eop.addr[31:LINE_BITS], 5'h00};
        mem.wdata <= 64'h0;
        rr        <= rr + 2'h1;
      end
    end
  end

  // Line state bits; hardware dirty marking wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NCACHE; k++) begin
        for (int s = 0; s < SETS; s++) begin
          vld[k][s] <= 4'h0;
          lck[k][s] <= 4'h0;
          drt[k][s] <= 4'h0;
        end
      end
    end else begin
      if (act_inv) begin
        vld[c][set][tway] <= 1'b0;                                   // RL12
        lck[c][set][tway] <= 1'b0;                                   // RL16
        drt[c][set][tway] <= 1'b0;
      end
      if (act_clean) begin
        drt[c][set][tway] <= 1'b0;                                   // RL15
      end
      if (act_sttag) begin
        vld[c][set][tway] <= stg_tag[STG_V_BIT];                     // RL10 RL23
        lck[c][set][tway] <= stg_tag[STG_L_BIT];                     // RL23
        drt[c][set][tway] <= 1'b0;
      end
      if (act_lock) begin
        lck[c][set][tway] <= 1'b1;                                   // RL16
      end
      if (act_fill) begin
        vld[c][set][tway] <= 1'b1;
        lck[c][set][tway] <= cur_lock;                               // RL16 RL17
        drt[c][set][tway] <= 1'b0;
      end
      for (int i = 0; i < WAYS; i++) begin
        if (dirty_valid && vld[1][dirty_addr[SET_LSB +: SET_BITS]][i]
            && tag_mem[1][dirty_addr[SET_LSB +: SET_BITS]][i] == dirty_addr[31:TAG_LSB]) begin
          drt[1][dirty_addr[SET_LSB +: SET_BITS]][i] <= 1'b1;
        end
      end
    end
  end

  // Tag and data arrays
  always_ff @(posedge clk_sys) begin
    if (act_sttag) begin
      tag_mem[c][set][tway] <= stg_tag[31:STG_TAG_LSB];             // RL10
    end
    if (act_stdata) begin
      data_mem[c][set][tway] <= stg_data;                            // RL11
    end
    if (act_fill) begin
      tag_mem[c][set][tway]  <= cur.addr[31:TAG_LSB];                // RL14
      data_mem[c][set][tway] <= mem_rdata;
    end
  end

  // Staging registers, cache op load beats a same-cycle software write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {itag_lo, itag_hi, idata_lo, idata_hi} <= {4{STAGE_RESET}};
      {dtag_lo, dtag_hi, ddata_lo}           <= {3{STAGE_RESET}};
      {l2tag_lo, l2data_lo, l2data_hi}       <= {3{STAGE_RESET}};
    end else begin
      if (cop_we) begin
        unique case (cop_regsel)
          REG_ITAG_LO:  itag_lo   <= cop_wdata;
          REG_ITAG_HI:  itag_hi   <= cop_wdata;
          REG_IDATA_LO: idata_lo  <= cop_wdata;
          REG_IDATA_HI: idata_hi  <= cop_wdata;
          REG_DTAG_LO:  dtag_lo   <= cop_wdata;
          REG_DTAG_HI:  dtag_hi   <= cop_wdata;
          REG_DDATA_LO: ddata_lo  <= cop_wdata;
          REG_L2TAG_LO: l2tag_lo  <= cop_wdata;
          REG_L2DAT_LO: l2data_lo <= cop_wdata;
          REG_L2DAT_HI: l2data_hi <= cop_wdata;
          default: ;
        endcase
      end
      if (act_ldtag) begin
        unique case (c)                                              // RL9
          2'h0: begin
            itag_lo  <= {tag_mem[c][set][tway], 9'(vl[tway] << STG_V_BIT)
                         | 9'(lk[tway] << STG_L_BIT)};               // RL23
            {idata_hi, idata_lo} <= data_mem[c][set][tway];
          end
          2'h1: begin
            dtag_lo  <= {tag_mem[c][set][tway], 9'(vl[tway] << STG_V_BIT)
                         | 9'(lk[tway] << STG_L_BIT)};
            ddata_lo <= data_mem[c][set][tway][31:0];
          end
          default: begin
            l2tag_lo <= {tag_mem[c][set][tway], 9'(vl[tway] << STG_V_BIT)
                         | 9'(lk[tway] << STG_L_BIT)};
            {l2data_hi, l2data_lo} <= data_mem[c][set][tway];
          end
        endcase
      end
    end
  end

  // Staging read port and younger-instruction replay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cop_rdata <= 32'h0;
      replay    <= 1'b0;
    end else begin
      unique case (cop_regsel)
        REG_ITAG_LO:  cop_rdata <= itag_lo;
        REG_ITAG_HI:  cop_rdata <= itag_hi;
        REG_IDATA_LO: cop_rdata <= idata_lo;
        REG_IDATA_HI: cop_rdata <= idata_hi;
        REG_DTAG_LO:  cop_rdata <= dtag_lo;
        REG_DTAG_HI:  cop_rdata <= dtag_hi;
        REG_DDATA_LO: cop_rdata <= ddata_lo;
        REG_L2TAG_LO: cop_rdata <= l2tag_lo;
        REG_L2DAT_LO: cop_rdata <= l2data_lo;
        REG_L2DAT_HI: cop_rdata <= l2data_hi;
        default:      cop_rdata <= 32'h0;
      endcase
      replay <= younger_valid && state != ST_IDLE                    // RL21
                && younger_addr[SET_LSB +: SET_BITS] == cur.addr[SET_LSB +: SET_BITS];
    end
  end

  chk_l3_no_effect: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL24
    accept && op.sel == SEL_L3 |=> op_done && !mem_valid)
    else $error("reserved selector op changed state or did not finish");
  chk_miss_one_clock: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL20
    accept && !fsb_hit && op.sel == SEL_DCACHE && op.cmd == CMD_HIT_INV |=> op_done && op_ready)
    else $error("hit invalidate did not finish in one clock");
  chk_hit_miss_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
    exec_go && eop.cmd == CMD_HIT_WB && !hit |=> !mem_valid && state == ST_IDLE)
    else $error("hit writeback acted on a miss");
  chk_fsb_stall: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL19
    accept && fsb_hit |=> mem_stall && !op_done)
    else $error("buffer match did not stall");
  chk_l2_slower: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL22
    accept && op.sel == SEL_L2 |=> !op_done ##1 !op_done ##1 !op_done)
    else $error("L2 op finished too soon");
  chk_wb_writes: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL8
    state == ST_WB && mem_valid |-> mem.write)
    else $error("writeback phase issued a read");
  chk_fill_reads: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4
    state == ST_FILL && mem_valid |-> !mem.write)
    else $error("fill phase issued a write");
  chk_replay_busy: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL21
    replay |-> $past(state) != ST_IDLE)
    else $error("replay raised while idle");
  chk_lock_keeps_one: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL17
    act_lock |=> !(&lck[$past(c)][$past(set)]))
    else $error("lock took the last unlocked way");

endmodule : cache_maintenance_op_unit

// file: pkg/cache_op_pkg.sv
package cache_op_pkg;
  // Cache selector codes
  localparam logic [1:0] SEL_ICACHE = 2'h0;
  localparam logic [1:0] SEL_DCACHE = 2'h1;
  localparam logic [1:0] SEL_L3     = 2'h2;
  localparam logic [1:0] SEL_L2     = 2'h3;
  // Command codes
  localparam logic [2:0] CMD_IDX_INV    = 3'h0;
  localparam logic [2:0] CMD_LD_TAG     = 3'h1;
  localparam logic [2:0] CMD_ST_TAG     = 3'h2;
  localparam logic [2:0] CMD_ST_DATA    = 3'h3;
  localparam logic [2:0] CMD_HIT_INV    = 3'h4;
  localparam logic [2:0] CMD_WBINV_FILL = 3'h5;
  localparam logic [2:0] CMD_HIT_WB     = 3'h6;
  localparam logic [2:0] CMD_FETCH_LOCK = 3'h7;
  // Geometry: 32-byte lines, 16 sets, 4 ways
  localparam int LINE_BITS = 5;
  localparam int SET_BITS  = 4;
  localparam int WAY_BITS  = 2;
  localparam int SETS      = 16;
  localparam int WAYS      = 4;
  localparam int SET_LSB   = LINE_BITS;
  localparam int WAY_LSB   = LINE_BITS + SET_BITS;
  localparam int TAG_LSB   = LINE_BITS + SET_BITS;
  localparam int TAG_W     = 32 - TAG_LSB;
  localparam int NCACHE    = 3;
  // Tag staging layout
  localparam int STG_TAG_LSB = TAG_LSB;
  localparam int STG_V_BIT   = 7;
  localparam int STG_L_BIT   = 5;
  // Staging register select codes {reg[4:0], sel[2:0]}
  localparam logic [7:0] REG_ITAG_LO  = 8'hE0;
  localparam logic [7:0] REG_ITAG_HI  = 8'hE8;
  localparam logic [7:0] REG_IDATA_LO = 8'hE1;
  localparam logic [7:0] REG_IDATA_HI = 8'hE9;
  localparam logic [7:0] REG_DTAG_LO  = 8'hE2;
  localparam logic [7:0] REG_DTAG_HI  = 8'hEA;
  localparam logic [7:0] REG_DDATA_LO = 8'hE3;
  localparam logic [7:0] REG_L2TAG_LO = 8'hE4;
  localparam logic [7:0] REG_L2DAT_LO = 8'hE5;
  localparam logic [7:0] REG_L2DAT_HI = 8'hED;
  localparam logic [31:0] STAGE_RESET = 32'h0;
  // Fill/store buffer queue depth and L2 operation length in L2 clocks
  localparam int         FSB_N       = 4;
  localparam logic [3:0] L2_OP_TICKS = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_WB   = 2'b11,
    ST_FILL = 2'b10
  } state_e;

  typedef enum logic [1:0] {
    POST_INV   = 2'h0,
    POST_CLEAN = 2'h1,
    POST_FILL  = 2'h2
  } post_e;

  typedef struct packed {
    logic [1:0]  sel;
    logic [2:0]  cmd;
    logic [31:0] addr;
  } cache_op_s;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
  } mem_req_s;
endpackage : cache_op_pkg

// file: verif/mem_model.sv
`timescale 1ns/1ns
// Memory side: acks each request, switching between prompt and slow answers after each read served
module mem_model
  import cache_op_pkg::*;
(
  input  wire logic       clk_sys,   // Core clock
  input  wire logic       resetn,    // Reset, active low
  input  wire logic       mem_valid, // Request held
  input  wire mem_req_s   mem,       // Request contents
  output logic            mem_ack,   // One-cycle done pulse
  output logic [63:0]     mem_rdata, // Fill data, toggles when idle
  output logic [7:0]      rd_count   // Reads served
);
  logic [2:0] wait_cnt;

  // Ack after 1 or 3 waits; idle data keeps changing so stale reads show
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 3'h0;
      rd_count  <= 8'h0;
      mem_rdata <= 64'h0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 3'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_valid && wait_cnt >= {1'b0, rd_count[0], 1'b1}) begin
      mem_ack   <= 1'b1;
      mem_rdata <= {mem.addr, ~mem.addr};
      rd_count  <= rd_count + {7'h0, !mem.write};
    end else begin
      wait_cnt  <= mem_valid ? wait_cnt + 3'h1 : 3'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_model

// file: verif/test_cache_maintenance_op_unit.sv
`timescale 1ns/1ns
module test_cache_maintenance_op_unit;
  import cache_op_pkg::*;
  logic clk_sys = 0, resetn = 0, op_valid = 0, cop_we = 0, rd_req = 0, rd_d = 0;
  logic op_ready, op_done, mem_stall, replay, mem_valid, mem_ack;
  logic younger_valid = 0, dirty_valid = 0;
  logic [31:0] younger_addr = 32'h0, dirty_addr = 32'h0;
  cache_op_s op = '0;
  mem_req_s mem;
  logic [FSB_N-1:0] fsb_valid = '0;
  logic [FSB_N*SET_BITS-1:0] fsb_index = '0;
  logic [1:0] l2_ratio = 2'h0;
  logic [7:0] cop_regsel = 8'h0, rd_count;
  logic [31:0] cop_wdata = 32'h0, cop_rdata, t, a, b;
  logic [63:0] mem_rdata, note, exp_q[$];
  int err_total = 0, comparisons = 0, wb_n = 0;

  cache_maintenance_op_unit DUT (.clk_sys(clk_sys), .resetn(resetn), .op_valid(op_valid),
    .op(op), .op_ready(op_ready), .op_done(op_done), .mem_stall(mem_stall), .replay(replay),
    .younger_valid(younger_valid), .younger_addr(younger_addr),
    .fsb_valid(fsb_valid), .fsb_index(fsb_index),
    .dirty_valid(dirty_valid), .dirty_addr(dirty_addr), .l2_ratio(l2_ratio), .cop_we(cop_we),
    .cop_regsel(cop_regsel), .cop_wdata(cop_wdata), .cop_rdata(cop_rdata),
    .mem_valid(mem_valid), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mem_model u_mem (.clk_sys(clk_sys), .resetn(resetn), .mem_valid(mem_valid), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rd_count(rd_count));

  // Clock and watchdog
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task end_sim;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Count finished writeback requests
  always @(posedge clk_sys) if (mem_valid && mem_ack && mem.write) wb_n <= wb_n + 1;

  // Staging read result lands one cycle after the select
  always @(posedge clk_sys) begin
    rd_d <= rd_req;
    if (rd_d) begin
      note = exp_q.pop_front();
      chk(cop_rdata & note[63:32], note[31:0] & note[63:32]);
    end
  end

  task wr(input logic [7:0] r, input logic [31:0] d);
    @(posedge clk_sys) begin cop_we <= 1'b1; cop_regsel <= r; cop_wdata <= d; end
    @(posedge clk_sys) cop_we <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] r, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys) begin cop_regsel <= r; rd_req <= 1'b1; end
    exp_q.push_back({m, e});
    @(posedge clk_sys) rd_req <= 1'b0;
  endtask : rd

  // Offer an op, hold it until taken, then wait for completion
  task run_op(input logic [1:0] s, input logic [2:0] c, input logic [31:0] ad);
    int n;
    n = 0;
    @(posedge clk_sys) begin op_valid <= 1'b1; op <= '{sel: s, cmd: c, addr: ad}; end
    do begin @(negedge clk_sys); n++; end while (op_ready !== 1'b1 && n < 500);
    @(posedge clk_sys) op_valid <= 1'b0;
    do begin @(negedge clk_sys); n++; end while (op_done !== 1'b1 && n < 1000);
    if (n >= 1000) chk(32'h0, 32'h1);
  endtask : run_op

  // Main sequence
  initial begin
    t = $urandom(84339);
    t = $urandom & 32'hFFFFFE00;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_DTAG_LO, STAGE_RESET, 32'hFFFFFFFF);
    wr(REG_DTAG_LO, t | 32'h80);
    rd(REG_DTAG_LO, t | 32'h80, 32'hFFFFFFFF);
    a = {t[31:9], 4'h3, 5'h0};
    run_op(SEL_DCACHE, CMD_ST_TAG, a);
    wr(REG_DTAG_LO, 32'h0);
    run_op(SEL_DCACHE, CMD_LD_TAG, a);
    rd(REG_DTAG_LO, t | 32'h80, 32'hFFFFFEA0);
    for (int c = 0; c < 8; c++) run_op(SEL_L3, 3'(c), a);
    run_op(SEL_DCACHE, CMD_LD_TAG, a);
    rd(REG_DTAG_LO, t | 32'h80, 32'hFFFFFEA0);
    @(posedge clk_sys) l2_ratio <= 2'($urandom);
    run_op(SEL_L2, CMD_HIT_INV, a);
    @(posedge clk_sys) begin fsb_index <= 16'h0003; fsb_valid <= 4'h1; end
    fork
      run_op(SEL_DCACHE, CMD_HIT_INV, a);
      begin
        repeat (6) @(negedge clk_sys);
        chk(32'(mem_stall), 32'h1);
        chk(32'(op_done), 32'h0);
        @(posedge clk_sys) begin fsb_valid <= 4'h0; younger_valid <= 1'b1; younger_addr <= a; end
        repeat (2) @(negedge clk_sys);
        chk(32'(replay), 32'h1);
        @(posedge clk_sys) younger_valid <= 1'b0;
        @(negedge clk_sys) chk(32'(replay), 32'h0);
      end
    join
    run_op(SEL_DCACHE, CMD_LD_TAG, a);
    rd(REG_DTAG_LO, 32'h0, 32'h000000A0);
    b = {t[31:9] ^ 23'h1, 4'h5, 5'h0};
    run_op(SEL_DCACHE, CMD_FETCH_LOCK, b);
    chk(32'(rd_count), 32'h1);
    run_op(SEL_DCACHE, CMD_FETCH_LOCK, b);
    chk(32'(rd_count), 32'h1);
    run_op(SEL_ICACHE, CMD_WBINV_FILL, b);
    chk(32'(rd_count), 32'h2);
    @(posedge clk_sys) begin dirty_valid <= 1'b1; dirty_addr <= b; end
    @(posedge clk_sys) dirty_valid <= 1'b0;
    run_op(SEL_DCACHE, CMD_HIT_WB, b);
    chk(32'(wb_n), 32'h1);
    run_op(SEL_DCACHE, CMD_WBINV_FILL, b);
    chk(32'(wb_n), 32'h1);
    run_op(SEL_DCACHE, CMD_FETCH_LOCK, b);
    chk(32'(rd_count), 32'h3);
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule : test_cache_maintenance_op_unit
